/* vsp_codec_model.sv */
// Behavioural codec that leads the voice link while the port is follower.
// Assumes the port samples on falling and launches on rising clock edges.
module vsp_codec_model (
  input  wire logic        i_en,        // Run frames while high
  input  wire logic        i_short,     // Short sync format
  input  wire logic [31:0] i_pattern,   // Frame bits 0..31, bit 0 in msb
  input  wire logic        i_dout,      // Port serial output
  input  wire logic        i_dout_oe_n, // Port output release
  output logic             o_clk,       // Bit clock to the port
  output logic             o_sync,      // Frame sync to the port
  output logic             o_din,       // Serial data to the port
  output logic      [31:0] o_cap_dout,  // Last frame output, bit 0 in msb
  output logic      [31:0] o_cap_oe,    // Last frame release, bit 0 in msb
  output int               o_frames     // Completed frames
);
  timeunit 1ns;
  timeprecision 1ps;
  int          cnt = 62;
  logic [31:0] cap_d;
  logic [31:0] cap_o;

  // Clock stands still while disabled; 30 ns period while running
  initial
  begin
    o_clk = 1'b0;
    o_sync = 1'b0;
    o_din = 1'b0;
    o_frames = 0;
    forever #15 o_clk = i_en ? ~o_clk : 1'b0;
  end

  // Launch sync and data on rising edges; 64 bit clocks a frame
  always @(posedge o_clk)
  begin
    cnt = (cnt == 63) ? 0 : cnt + 1;
    o_sync <= i_short ? (cnt == 63) : (cnt < 8);
    // Past the slots the line toggles, so a stale bit never reads as data
    o_din <= (cnt < 32) ? i_pattern[31 - cnt] : cnt[0];
  end

  // Sample the port on falling edges, publish at frame end
  always @(negedge o_clk)
  begin
    if (cnt < 32)
    begin
      cap_d[31 - cnt] = i_dout;
      cap_o[31 - cnt] = i_dout_oe_n;
    end
    if (cnt == 63)
    begin
      o_cap_dout <= cap_d;
      o_cap_oe <= cap_o;
      o_frames <= o_frames + 1;
    end
  end
endmodule

/* vsp_pkg.sv */
// Constants, encodings and sample-packing helpers of the voice sample port.
// Assumes a 250 MHz system clock and a bit clock of at most 4.096 MHz.
package vsp_pkg;
  // ----------------------------------------------------------------
  // Clocking and frame timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ      = 250_000_000;
  localparam longint BCLK_128_HZ = 128_000;
  localparam longint BCLK_256_HZ = 256_000;
  localparam longint BCLK_512_HZ = 512_000;
  localparam longint FRAME_HZ    = 8_000;
  // Phase steps of the bit clock oscillator
  localparam logic [31:0] INC_128 = 32'((BCLK_128_HZ << 32) / CLK_HZ);
  localparam logic [31:0] INC_256 = 32'((BCLK_256_HZ << 32) / CLK_HZ);
  localparam logic [31:0] INC_512 = 32'((BCLK_512_HZ << 32) / CLK_HZ);
  // Bit clocks per frame in leader role
  localparam logic [6:0] FLEN_128 = 7'(BCLK_128_HZ / FRAME_HZ);
  localparam logic [6:0] FLEN_256 = 7'(BCLK_256_HZ / FRAME_HZ);
  localparam logic [6:0] FLEN_512 = 7'(BCLK_512_HZ / FRAME_HZ);
  localparam logic [6:0] LSYNC_LEN = 7'h08;
  // ----------------------------------------------------------------
  // Configuration word layout
  // ----------------------------------------------------------------
  localparam logic [11:0] CFG_KEY_ID = 12'h1B3;
  localparam logic [31:0] CFG_RESET  = 32'h0080_0000;
  localparam int ROLE_BIT = 1;
  localparam int SHORT_BIT = 2;
  localparam int SIGNX_BIT = 4;
  localparam int LSB_BIT = 5;
  localparam int TRI_BIT = 6;
  localparam int TRIR_BIT = 7;
  localparam int SUPP_BIT = 8;
  localparam int GCI_BIT = 9;
  localparam int MUTE_BIT = 10;
  localparam int RATE_LSB = 21;
  localparam int SLOT_LSB = 23;
  localparam int FMT_LSB = 27;
  localparam logic [1:0] RATE_128 = 2'h1;
  localparam logic [1:0] RATE_512 = 2'h2;
  localparam logic [1:0] FMT_13 = 2'h0;
  localparam logic [1:0] FMT_16 = 2'h1;
  localparam logic [1:0] FMT_8W = 2'h2;
  localparam logic [1:0] FMT_8N = 2'h3;
  localparam logic [3:0] GCI_MASK = 4'h3;
  // ----------------------------------------------------------------
  // Sample packing
  // ----------------------------------------------------------------
  // Slot word, bit 0 is the least significant serial bit
  function automatic logic [15:0] vsp_pack(input logic [1:0] fmt, input logic sx,
                                           input logic [2:0] gain, input logic [15:0] s);
    case (fmt)
      FMT_13:  vsp_pack = sx ? {{3{s[12]}}, s[12:0]} : {s[12:0], gain};
      FMT_16:  vsp_pack = s;
      FMT_8W:  vsp_pack = sx ? {{8{s[7]}}, s[7:0]} : {s[7:0], 8'h00};
      default: vsp_pack = {8'h00, s[7:0]};
    endcase
  endfunction
  function automatic logic [15:0] vsp_unpack(input logic [1:0] fmt, input logic sx,
                                             input logic [15:0] w);
    case (fmt)
      FMT_13:  vsp_unpack = sx ? {3'h0, w[12:0]} : {3'h0, w[15:3]};
      FMT_16:  vsp_unpack = w;
      FMT_8W:  vsp_unpack = sx ? {8'h00, w[7:0]} : {8'h00, w[15:8]};
      default: vsp_unpack = {8'h00, w[7:0]};
    endcase
  endfunction
endpackage

/* vsp_port.sv */
// Voice sample serial port: leader/follower, long/short sync, GCI.
// Assumes i_link_clk is the bit clock as seen at the pad (looped back in
// leader role) and that the config word changes only while the port idles.
module vsp_port
  import vsp_pkg::*;
#(
  parameter int NSLOT = 4
)(
  input  wire logic        i_clock,        // System clock, 250 MHz
  input  wire logic        i_sys_rst,      // Async reset, active high
  input  wire logic [31:0] i_cfg_word,     // Port config record
  input  wire logic [2:0]  i_gain,         // Attenuation code for padding
  input  wire logic [63:0] i_tx_samples,   // Four slot samples, slot 0 low
  output logic      [63:0] o_rx_samples,   // Received samples, slot 0 low
  output logic             o_frame_pulse,  // One cycle per frame
  input  wire logic        i_link_clk,     // Bit clock at the pad
  output logic             o_bclk,         // Generated bit clock
  output logic             o_bclk_oe_n,    // Low while driving bit clock
  input  wire logic        i_sync,         // Sync pin level
  output logic             o_sync,         // Generated sync
  output logic             o_sync_oe_n,    // Low while driving sync
  input  wire logic        i_din,          // Serial data in
  output logic             o_dout,         // Serial data out
  output logic             o_dout_oe_n     // Low while driving data out
);
  initial
  begin
    if (NSLOT != 4)
      $error("vsp_port supports exactly four slots");
  end
  // ----------------------------------------------------------------
  // System domain: bit clock oscillator
  // ----------------------------------------------------------------
  logic [31:0] nco_r;
  logic        bclk_r;
  logic [31:0] inc;
  always_comb
  begin
    case (i_cfg_word[RATE_LSB+:2])
      RATE_128: inc = INC_128;
      RATE_512: inc = INC_512;
      default:  inc = INC_256;
    endcase
  end
  // Phase accumulator; 4 ns jitter traded for any rate from one clock
  always_ff @(posedge i_clock or posedge i_sys_rst)
    if (i_sys_rst)
    begin
      nco_r  <= 32'h0000_0000;
      bclk_r <= 1'b0;
    end
    else
    begin
      nco_r  <= nco_r + inc;
      bclk_r <= nco_r[31];
    end
  assign o_bclk      = bclk_r;
  assign o_bclk_oe_n = i_cfg_word[ROLE_BIT];
  // ----------------------------------------------------------------
  // Link domain: reset and configuration
  // ----------------------------------------------------------------
  logic [1:0]  lrst_r;
  logic        lrst;
  logic [31:0] cfg_l;
  logic [63:0] tx_sys_r;
  always_ff @(posedge i_link_clk or posedge i_sys_rst)
    if (i_sys_rst)
      lrst_r <= 2'h3;
    else
      lrst_r <= {lrst_r[0], 1'b0};
  assign lrst = lrst_r[1];
  // Loaded with CFG_RESET by the system reset so the word has settled before the link
  // logic leaves reset; otherwise the first frame runs on default options
  vsp_sync #(.W(32), .RST(CFG_RESET)) u_cfg_sync (
    .i_clk (i_link_clk),
    .i_rst (i_sys_rst),
    .i_d   (i_cfg_word),
    .o_q   (cfg_l)
  );
  // Decoded options; GCI forces two narrow 8-bit bearer slots
  logic       follower;
  logic       short_fs;
  logic       gci;
  logic [1:0] fmt;
  logic       sx;
  logic       lsb;
  logic       wide;
  logic [3:0] mask;
  logic [6:0] flen;
  logic [6:0] span;
  assign follower = cfg_l[ROLE_BIT];
  assign gci      = cfg_l[GCI_BIT];
  assign short_fs = cfg_l[SHORT_BIT] & ~gci;
  assign fmt      = gci ? FMT_8N : cfg_l[FMT_LSB+:2];
  assign sx       = cfg_l[SIGNX_BIT];
  assign lsb      = cfg_l[LSB_BIT];
  assign wide     = (fmt != FMT_8N);
  assign span     = wide ? 7'h40 : 7'h20;
  // A fourth enabled slot is dropped to keep at most three links
  assign mask     = gci ? GCI_MASK : ((&cfg_l[SLOT_LSB+:4]) ? 4'h7
                                                           : cfg_l[SLOT_LSB+:4]);
  always_comb
  begin
    case (cfg_l[RATE_LSB+:2])
      RATE_128: flen = FLEN_128;
      RATE_512: flen = FLEN_512;
      default:  flen = FLEN_256;
    endcase
  end
  // Position valid and slot enabled; bits beyond a short frame are dead
  function automatic logic act_at(input logic [6:0] p);
    logic [1:0] s;
    s = wide ? p[5:4] : p[4:3];
    act_at = (p < span) && (follower || p < flen) && mask[s];
  endfunction
  function automatic logic [3:0] bit_at(input logic [6:0] p);
    logic [3:0] k;
    k = wide ? p[3:0] : {1'b0, p[2:0]};
    bit_at = lsb ? k : ((wide ? 4'hF : 4'h7) - k);
  endfunction
  function automatic logic [1:0] slot_at(input logic [6:0] p);
    slot_at = wide ? p[5:4] : p[4:3];
  endfunction
  // Position inside the frame, or bit 0 of the next frame once past its end
  function automatic logic [6:0] wrap_pos(input logic [6:0] p);
    wrap_pos = (p < span && (follower || p < flen)) ? p : 7'h00;
  endfunction
  // ----------------------------------------------------------------
  // Link domain, falling edge: sync detect, capture, bit position
  // ----------------------------------------------------------------
  logic        sprev_r;
  logic [6:0]  bpos_r;
  logic        tog_r;
  logic        ofall_r;
  logic [15:0] rxw_r [4];
  logic [63:0] rx_hold_r;
  logic [15:0] txw_r [4];
  logic        start;
  logic [6:0]  cur;
  // Word starts on the sync edge of the chosen polarity
  assign start = short_fs ? (sprev_r & ~i_sync) : (~sprev_r & i_sync);
  assign cur   = start ? 7'h00 : bpos_r;
  // Counts pad clock edges only, so any bit clock rate up to the limit works
  always_ff @(negedge i_link_clk or posedge lrst)
    if (lrst)
    begin
      sprev_r <= 1'b0;
      bpos_r  <= 7'h7F;
    end
    else
    begin
      sprev_r <= i_sync;
      if (start)
        bpos_r <= 7'h01;
      else if (bpos_r != 7'h7F)
        bpos_r <= bpos_r + 7'h01;
    end
  // Input is sampled on the falling edge into the slot word
  always_ff @(negedge i_link_clk or posedge lrst)
    if (lrst)
      for (int i = 0; i < 4; i++)
        rxw_r[i] <= 16'h0000;
    else if (act_at(cur))
      rxw_r[slot_at(cur)][bit_at(cur)] <= i_din;
  // At each start the last frame is handed over and new data taken
  always_ff @(negedge i_link_clk or posedge lrst)
    if (lrst)
    begin
      tog_r     <= 1'b0;
      rx_hold_r <= 64'h0;
      for (int i = 0; i < 4; i++)
        txw_r[i] <= 16'h0000;
    end
    else if (start)
    begin
      tog_r <= ~tog_r;
      for (int i = 0; i < 4; i++)
      begin
        rx_hold_r[16*i+:16] <= vsp_unpack(fmt, sx, rxw_r[i]);
        txw_r[i]            <= vsp_pack(fmt, sx, i_gain, tx_sys_r[16*i+:16]);
      end
    end
  // Release right after the falling edge when the next bit is idle
  always_ff @(negedge i_link_clk or posedge lrst)
    if (lrst)
      ofall_r <= 1'b1;
    else
      ofall_r <= ~act_at(wrap_pos(cur + 7'h01));
  // ----------------------------------------------------------------
  // Link domain, rising edge: sync generation and data launch
  // ----------------------------------------------------------------
  logic [6:0] fcnt_r;
  logic       sync_r;
  logic       dout_r;
  logic       orise_r;
  logic [6:0] pos;
  // After the frame the first bit of slot 0 waits on the line, so a
  // follower drives it before it has seen the sync edge
  always_comb
  begin
    pos = wrap_pos(bpos_r);
  end
  // Starts past the frame end so a long-sync first frame opens with a full sync
  always_ff @(posedge i_link_clk or posedge lrst)
    if (lrst)
      fcnt_r <= 7'h7F;
    else if (fcnt_r >= flen - 7'h01)
      fcnt_r <= 7'h00;
    else
      fcnt_r <= fcnt_r + 7'h01;
  always_ff @(posedge i_link_clk or posedge lrst)
    if (lrst)
      sync_r <= 1'b0;
    else if (follower || cfg_l[SUPP_BIT])
      sync_r <= 1'b0;
    else if (short_fs)
      sync_r <= (fcnt_r == flen - 7'h02);
    else
      sync_r <= (fcnt_r >= flen - 7'h01) || (fcnt_r < LSYNC_LEN - 7'h01);
  always_ff @(posedge i_link_clk or posedge lrst)
    if (lrst)
    begin
      dout_r  <= 1'b0;
      orise_r <= 1'b1;
    end
    else
    begin
      orise_r <= ~act_at(pos);
      if (cfg_l[MUTE_BIT] || !act_at(pos))
        dout_r <= 1'b0;
      else
        dout_r <= txw_r[slot_at(pos)][bit_at(pos)];
    end
  assign o_sync      = sync_r;
  assign o_sync_oe_n = follower;
  assign o_dout      = dout_r;
  assign o_dout_oe_n = cfg_l[TRI_BIT] & (cfg_l[TRIR_BIT] ? orise_r : ofall_r);
  // ----------------------------------------------------------------
  // System domain: frame handshake
  // ----------------------------------------------------------------
  logic tog_s;
  logic tog_d_r;
  vsp_sync #(.W(1), .RST(1'b0)) u_tog_sync (
    .i_clk (i_clock),
    .i_rst (i_sys_rst),
    .i_d   (tog_r),
    .o_q   (tog_s)
  );
  // Received words are read within three system clocks of settling, sent words a frame after, so no gray code is needed
  always_ff @(posedge i_clock or posedge i_sys_rst)
    if (i_sys_rst)
    begin
      tog_d_r       <= 1'b0;
      o_frame_pulse <= 1'b0;
      o_rx_samples  <= 64'h0;
      tx_sys_r      <= 64'h0;
    end
    else
    begin
      tog_d_r       <= tog_s;
      o_frame_pulse <= tog_s ^ tog_d_r;
      if (tog_s ^ tog_d_r)
      begin
        o_rx_samples <= rx_hold_r;
        tx_sys_r     <= i_tx_samples;
      end
    end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_long_pulse;
    sync_r [*8] ##1 !sync_r;
  endsequence
  a_long_sync_len: assert property (@(posedge i_link_clk) disable iff (lrst)
    $rose(sync_r) && !short_fs && !follower && $stable(cfg_l) |-> s_long_pulse)
    else $error("leader long sync not eight clocks");
  a_short_sync_one: assert property (@(posedge i_link_clk) disable iff (lrst)
    $rose(sync_r) && short_fs |=> !sync_r)
    else $error("short sync longer than one clock");
  a_mute_forces_zero: assert property (@(posedge i_link_clk) disable iff (lrst)
    cfg_l[MUTE_BIT] |=> !dout_r)
    else $error("data out not zero while muted");
  a_sync_suppressed: assert property (@(posedge i_link_clk) disable iff (lrst)
    cfg_l[SUPP_BIT] && !follower |=> !sync_r)
    else $error("sync driven while suppressed");
  a_frame_wrap: assert property (@(posedge i_link_clk) disable iff (lrst)
    fcnt_r == flen - 7'h01 |=> fcnt_r == 7'h00)
    else $error("frame counter did not wrap at frame length");
  a_slot_start: assert property (@(negedge i_link_clk) disable iff (lrst)
    start |=> bpos_r == 7'h01 ##1 bpos_r == 7'h02)
    else $error("bit position not counting from frame start");
  a_three_links: assert property (@(posedge i_link_clk) disable iff (lrst)
    !(&mask))
    else $error("more than three slots active");
  a_bclk_runs: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    !i_cfg_word[ROLE_BIT] |-> ##[1:1000] (bclk_r != $past(bclk_r)))
    else $error("leader bit clock stalled");
  a_drive_when_no_tri: assert property (@(posedge i_link_clk) disable iff (lrst)
    !cfg_l[TRI_BIT] |-> !o_dout_oe_n)
    else $error("data out released with tristate off");
endmodule

/* vsp_port_tb_top.sv */
// Self-checking bench of the voice sample port in leader and follower roles.
// Assumes the codec model file is compiled first; leader loops clock back.
`define CHK(n, e, g) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      failures++; \
      $display("[FAIL] %s expected %0h seen %0h", n, e, g); \
    end \
  end

module vsp_port_tb_top
  import vsp_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, fp, bclk, bclk_oe_n, sync_out, sync_oe_n, dout, dout_oe_n;
  logic        cclk, csync, cdin, lclk, sync_in, seen;
  logic [31:0] cfg, pat, cap_d, cap_o;
  logic [63:0] tx, o_rx;
  int          frames, failures, tests_run, n, p, e, w;
  logic [1:0]  rsel [3] = '{RATE_128, 2'h0, RATE_512};
  longint      rhz [3] = '{BCLK_128_HZ, BCLK_256_HZ, BCLK_512_HZ};

  // Leader loops its own clock and sync back to the pads
  assign lclk = cfg[1] ? cclk : bclk;
  assign sync_in = cfg[1] ? csync : sync_out;

  vsp_port uut (.i_clock(clk), .i_sys_rst(rst), .i_cfg_word(cfg), .i_gain(3'h5),
    .i_tx_samples(tx), .o_rx_samples(o_rx), .o_frame_pulse(fp), .i_link_clk(lclk),
    .o_bclk(bclk), .o_bclk_oe_n(bclk_oe_n), .i_sync(sync_in), .o_sync(sync_out),
    .o_sync_oe_n(sync_oe_n), .i_din(cdin), .o_dout(dout), .o_dout_oe_n(dout_oe_n));

  vsp_codec_model codec (.i_en(cfg[1]), .i_short(cfg[2]), .i_pattern(pat),
    .i_dout(dout), .i_dout_oe_n(dout_oe_n), .o_clk(cclk), .o_sync(csync),
    .o_din(cdin), .o_cap_dout(cap_d), .o_cap_oe(cap_o), .o_frames(frames));

  // System clock, 4 ns
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic results();
    if (failures == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Bounded poll of the generated bit clock; n counts system clocks
  task automatic wait_bclk(input logic v, output int k);
    k = 0;
    while (bclk !== v && k < 40000)
    begin
      @(negedge clk);
      k++;
    end
    if (k >= 40000)
      failures++;
  endtask

  // Width of the next generated sync pulse, and whether a frame pulse fell inside
  task automatic sync_width(output int w, output logic s);
    int k;
    k = 0;
    w = 0;
    s = 1'b0;
    while (sync_out !== 1'b1 && k < 40000)
    begin
      @(negedge clk);
      k++;
    end
    while (sync_out === 1'b1 && w < 8000)
    begin
      @(negedge clk);
      w++;
      if (fp === 1'b1)
        s = 1'b1;
    end
    if (k >= 40000 || w >= 8000)
      failures++;
  endtask

  // Config only changes under reset, since the port resyncs it as a static word
  task automatic apply(input logic [31:0] c);
    @(negedge clk);
    rst = 1'b1;
    cfg = c;
    repeat (40) @(negedge clk);
    rst = 1'b0;
    repeat (40) @(negedge clk);
  endtask

  // One follower run: five codec frames, then the last frame is judged
  task automatic run_f(input logic [31:0] c, input logic [31:0] t, input logic [31:0] pt,
                       input logic [31:0] edo, input logic [31:0] eoe,
                       input logic [31:0] erx, input logic [31:0] m);
    int f0;
    int k;
    tx = {t, t};
    pat = pt;
    apply(c);
    f0 = frames;
    k = 0;
    while (frames < f0 + 5 && k < 10000)
    begin
      @(negedge clk);
      k++;
    end
    if (k >= 10000)
      failures++;
    `CHK("serial out", edo, cap_d)
    `CHK("out release", eoe, cap_o)
    `CHK("rx samples", erx, o_rx[31:0] & m)
    `CHK("follower oe_n", 2'h3, {bclk_oe_n, sync_oe_n})
  endtask

  // Watchdog: well beyond the longest expected run
  initial
  begin
    // About 95k system clocks; the tests need roughly 70k
    #380000;
    failures++;
    results();
  end

  initial
  begin
    failures = 0;
    tests_run = 0;
    rst = 1'b1;
    cfg = CFG_RESET;
    tx = 64'h0;
    pat = 32'h0;
    repeat (5) @(negedge clk);
    `CHK("reset outputs", 67'h0, {o_rx, fp, sync_out, dout})
    `CHK("reset bclk oe_n", 1'b0, bclk_oe_n)
    rst = 1'b0;
    // Leader bit clock period at each rate, NCO jitter of one clock allowed
    for (int k = 0; k < 3; k++)
    begin
      apply(CFG_RESET & 32'hFF9F_FFFF | (32'(rsel[k]) << RATE_LSB));
      wait_bclk(1'b0, n);
      wait_bclk(1'b1, n);
      wait_bclk(1'b0, n);
      p = n;
      wait_bclk(1'b1, n);
      p += n;
      e = int'(CLK_HZ / rhz[k]);
      `CHK("bclk period", 1'b1, (p >= e && p <= e + 1))
      `CHK("leader oe_n", 2'h0, {bclk_oe_n, sync_oe_n})
    end
    // Leader long sync at 512 kHz: 8 bit clocks wide, frame seen inside it
    apply(32'h00C0_0000);
    sync_width(w, seen);
    `CHK("sync width", 1'b1, (w >= 3900 && w <= 3912))
    `CHK("frame pulse", 1'b1, seen)
    // Sync suppressed; the window covers the first frame start after reset
    apply(32'h00C0_0000 | (32'h1 << SUPP_BIT));
    seen = 1'b0;
    repeat (6000)
    begin
      @(negedge clk);
      if (sync_out !== 1'b0)
        seen = 1'b1;
    end
    `CHK("sync held low", 1'b0, seen)
    wait_bclk(1'b1, n);
    wait_bclk(1'b0, n);
    `CHK("bclk running", 1'b1, (n < 600))
    // Leader short sync at 256 kHz: exactly one bit clock wide
    apply(CFG_RESET | (32'h1 << SHORT_BIT));
    sync_width(w, seen);
    `CHK("short sync width", 1'b1, (w >= 970 && w <= 982))
    // Follower runs: formats, orders, padding, mute, release, GCI
    run_f(32'h19800002, 32'h003C00A5, 32'h5AC30000,
          32'hA53C0000, 32'h0, 32'h00C3005A, 32'hFFFFFFFF);
    run_f(32'h09800026, 32'h00001234, 32'h80010000,
          32'h2C480000, 32'h0, 32'h00008001, 32'hFFFFFFFF);
    run_f(32'h18800442, 32'h000000A5, 32'h5A000000,
          32'h0, 32'h00FFFFFF, 32'h0000005A, 32'h0000FFFF);
    run_f(32'h00800202, 32'h007E0081, 32'h0FF00000,
          32'h817E0000, 32'h0, 32'h00F0000F, 32'hFFFFFFFF);
    run_f(32'h00800002, 32'h00001ABC, 32'h12380000,
          32'hD5E50000, 32'h0, 32'h00000247, 32'h0000FFFF);
    run_f(32'h10800012, 32'h00000085, 32'h00C70000,
          32'hFF850000, 32'h0, 32'h000000C7, 32'h0000FFFF);
    run_f(32'h188000C2, 32'h000000A5, 32'h5A000000,
          32'hA5000000, 32'h00FFFFFF, 32'h0000005A, 32'h0000FFFF);
    run_f(32'h1F800002, 32'h44332211, 32'hA1B2C3D4,
          32'h11331100, 32'h0, 32'h00B200A1, 32'hFFFFFFFF);
    results();
  end
endmodule

/* vsp_sync.sv */
// Two-stage synchroniser for levels and quasi-static words.
// Assumes a multi-bit input changes only while the receiver ignores it.
module vsp_sync
  import vsp_pkg::*;
#(
  parameter int          W   = 1,
  parameter logic [W-1:0] RST = '0
)(
  input  wire logic         i_clk,   // Receiving clock
  input  wire logic         i_rst,   // Async reset, active high
  input  wire logic [W-1:0] i_d,     // Foreign-domain input
  output logic      [W-1:0] o_q      // Synchronised output
);
  logic [W-1:0] meta_r;
  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  // The first stage feeds only the second one
  always_ff @(posedge i_clk or posedge i_rst)
    if (i_rst)
    begin
      meta_r <= RST;
      o_q    <= RST;
    end
    else
    begin
      meta_r <= i_d;
      o_q    <= meta_r;
    end
endmodule
